// ### design/phy_media_timing.sv
// Top: MAC-side clocks, sampling edges and line latencies of one 10/100 port
`timescale 1ns/1ps
// What this block does
// - 100M: J begins 5 bit times after first TX clock rise with enable.
// - 100M: T begins 5 bit times after first TX clock rise without enable.
// - 100M: carrier sense 20 bits after J; receive data 24 bits latency.
// - 100M: carrier sense drops 24 bit times after first T bit.
// - 100M: bit time 10 ns; TX and RX clocks 20 ns high, 20 low.
// - 10M nibble mode samples transmit data and enable on TX clock fall.
// - 10M nibble mode TX clock is 200 ns high, 200 ns low.
// - 10M nibble receive outputs settle 200 ns before RX clock rise.
// - RX clock may stretch a phase on source change, never shorten it.
// - 10M bit time is 100 ns, the unit of all 10M latencies.
// - Serial mode TX clock 30 ns high, 70 low, sampled on rise.
// - Serial RX clock 50/50 ns; receive bit and valid change on fall.
// - 10M line output starts 3.5 bit times after the sampling edge.
// - 10M end of packet holds line high 300 ns, never under 250.
module phy_media_timing
    import phy_timing_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)
(
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [1:0] MODE_SEL,
    input wire logic TX_EN,
    input wire logic [NIB_W-1:0] TXD,
    output logic TX_CLK,
    output logic RX_CLK,
    output logic [NIB_W-1:0] RXD,
    output logic RX_DV,
    output logic CRS,
    output logic TX_LOST,
    output logic LINE_TXD,
    output logic LINE_TX_ACTIVE,
    output logic LINE_TX_SOS,
    output logic LINE_TX_EOS,
    input wire logic LINE_RCLK,
    input wire logic LINE_RX_ACTIVE,
    input wire logic LINE_RXD
);
    if (FIFO_DEPTH < 4)
    begin : g_chk
        $error("FIFO_DEPTH must be at least 4");
    end
    if (EOP_CYC < EOP_MIN_CYC)
    begin : g_eop_chk
        $error("end of packet high time below its minimum");
    end

    function automatic logic [CW-1:0] tx_half(input mode_t m, input logic hi);
        unique case (m)
            MODE_100: return TX100_HALF_CYC;
            MODE_10NIB: return TX10N_HALF_CYC;
            MODE_10SER: return hi ? TXSER_HI_CYC : TXSER_LO_CYC;
        endcase
    endfunction

    function automatic logic [CW-1:0] rx_half(input mode_t m);
        unique case (m)
            MODE_100: return TX100_HALF_CYC;
            MODE_10NIB: return RX10N_HALF_CYC;
            MODE_10SER: return RXSER_HALF_CYC;
        endcase
    endfunction

    // Pin synchronisers
    logic [1:0] mode_q1;
    logic [1:0] mode_q2;
    logic txen_q1;
    logic txen_s;
    logic [NIB_W-1:0] txd_q1;
    logic [NIB_W-1:0] txd_s;
    logic ract_q1;
    logic ract_s;
    logic rclk_q1;
    logic rclk_s;
    logic rclk_d;
    logic rxd_q1;
    logic rxd_s;

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            {mode_q1, mode_q2} <= '0;
            {txen_q1, txen_s, txd_q1, txd_s} <= '0;
            {ract_q1, ract_s, rclk_q1, rclk_s, rclk_d, rxd_q1, rxd_s} <= '0;
        end
        else
        begin
            mode_q1 <= MODE_SEL;
            mode_q2 <= mode_q1;
            txen_q1 <= TX_EN;
            txen_s <= txen_q1;
            txd_q1 <= TXD;
            txd_s <= txd_q1;
            ract_q1 <= LINE_RX_ACTIVE;
            ract_s <= ract_q1;
            rclk_q1 <= LINE_RCLK;
            rclk_s <= rclk_q1;
            rclk_d <= rclk_s;
            rxd_q1 <= LINE_RXD;
            rxd_s <= rxd_q1;
        end
    end

    // The unused code 2'b10 falls back to 100M
    wire mode_t mode = (mode_q2 == 2'h2) ? MODE_100 : mode_t'(mode_q2);
    wire m100 = (mode == MODE_100);
    wire m10nib = (mode == MODE_10NIB);
    wire m10ser = (mode == MODE_10SER);
    wire [CW-1:0] bit_cyc = m100 ? BIT100_CYC : BIT10_CYC;
    wire [2:0] word_bits = m10ser ? 3'h1 : 3'h4;
    wire rcv_edge = rclk_s && !rclk_d;

    // Transmit clock divider
    logic tx_clk;
    logic [CW-1:0] tx_cnt;
    wire [CW-1:0] tx_len = tx_half(mode, tx_clk);
    wire tx_phase_end = (tx_cnt >= tx_len - ONE_C);
    wire tx_rise_ev = tx_phase_end && !tx_clk;
    wire tx_fall_ev = tx_phase_end && tx_clk;
    // MAC launches on rise, so nibble data is steady at the fall
    wire samp_ev = m10nib ? tx_fall_ev : tx_rise_ev;

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            tx_clk <= 1'b0;
            tx_cnt <= '0;
        end
        else if (tx_phase_end)
        begin
            tx_clk <= !tx_clk;
            tx_cnt <= '0;
        end
        else
        begin
            tx_cnt <= tx_cnt + ONE_C;
        end
    end
    assign TX_CLK = tx_clk;

    // Transmit sampling into the FIFO; a marker word closes each packet
    logic tx_busy;
    wire push_ev = samp_ev && (txen_s || tx_busy);
    wire start_ev = samp_ev && txen_s && !tx_busy;
    wire stop_ev = samp_ev && !txen_s && tx_busy;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [WORD_W-1:0] fifo_out_data;
    wire [WORD_W-1:0] fifo_in_data = {!txen_s, m10ser ? {3'h0, txd_s[0]} : txd_s};

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            tx_busy <= 1'b0;
            TX_LOST <= 1'b0;
        end
        else
        begin
            if (samp_ev)
            begin
                tx_busy <= txen_s;
            end
            // Loss at the first sample still sticks
            if (push_ev && !fifo_in_ready)
            begin
                TX_LOST <= 1'b1;
            end
            else if (start_ev)
            begin
                TX_LOST <= 1'b0;
            end
        end
    end

    // Line-side serialiser
    tx_state_t tx_state;
    logic [CW-1:0] line_cnt;
    logic [CW-1:0] bit_tmr;
    logic [2:0] bits_left;
    logic [NIB_W-1:0] tx_shift;
    wire bit_done = (bit_tmr >= bit_cyc - ONE_C);
    wire lead_pop = (tx_state == TXS_LEAD) && (line_cnt == '0);
    wire data_pop = (tx_state == TXS_DATA) && bit_done && (bits_left == 3'h1);
    wire pop = fifo_out_valid && (lead_pop || data_pop);
    wire take = pop && !fifo_out_data[MARK_BIT];
    wire endw = pop && fifo_out_data[MARK_BIT];
    wire tail_done = (tx_state == TXS_TAIL) && (line_cnt == '0);
    // Count covers the FIFO pass and the IDLE cycle
    wire [CW-1:0] lead_len = (m100 ? TX100_LEAD_CYC : TX10_LEAD_CYC) - ONE_C - ONE_C;
    wire [CW-1:0] tail_len = m100 ? ONE_C : EOP_CYC;

    media_fifo #(
        .W(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .in_valid(push_ev),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(lead_pop || data_pop),
        .out_data(fifo_out_data)
    );

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            tx_state <= TXS_IDLE;
            line_cnt <= '0;
            LINE_TX_ACTIVE <= 1'b0;
            LINE_TX_SOS <= 1'b0;
            LINE_TX_EOS <= 1'b0;
        end
        else
        begin
            LINE_TX_SOS <= take && (tx_state == TXS_LEAD);
            LINE_TX_EOS <= endw;
            unique case (tx_state)
                TXS_IDLE:
                begin
                    if (fifo_out_valid)
                    begin
                        tx_state <= TXS_LEAD;
                        line_cnt <= lead_len;
                    end
                end
                TXS_LEAD:
                begin
                    if (line_cnt != '0)
                    begin
                        line_cnt <= line_cnt - ONE_C;
                    end
                    else if (take)
                    begin
                        tx_state <= TXS_DATA;
                        LINE_TX_ACTIVE <= 1'b1;
                    end
                end
                TXS_DATA:
                begin
                    if (endw)
                    begin
                        tx_state <= TXS_TAIL;
                        line_cnt <= tail_len - ONE_C;
                    end
                end
                TXS_TAIL:
                begin
                    if (tail_done)
                    begin
                        tx_state <= TXS_IDLE;
                        LINE_TX_ACTIVE <= 1'b0;
                    end
                    else
                    begin
                        line_cnt <= line_cnt - ONE_C;
                    end
                end
            endcase
        end
    end

    // Bit stream, low bit of each nibble first
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            LINE_TXD <= 1'b0;
            tx_shift <= '0;
            bits_left <= '0;
            bit_tmr <= '0;
        end
        else if (take)
        begin
            LINE_TXD <= fifo_out_data[0];
            tx_shift <= fifo_out_data[NIB_W-1:0];
            bits_left <= word_bits;
            bit_tmr <= '0;
        end
        else if (endw)
        begin
            // High whatever the last bit was
            LINE_TXD <= 1'b1;
        end
        else if (tail_done)
        begin
            LINE_TXD <= 1'b0;
        end
        else if (tx_state == TXS_DATA && !bit_done)
        begin
            bit_tmr <= bit_tmr + ONE_C;
        end
        else if (tx_state == TXS_DATA && bits_left > 3'h1)
        begin
            LINE_TXD <= tx_shift[1];
            tx_shift <= tx_shift >> 1;
            bits_left <= bits_left - 3'h1;
            bit_tmr <= '0;
        end
    end

    // Carrier sense with separate on and off delays
    logic [CW-1:0] crs_cnt;
    wire [CW-1:0] crs_len = ract_s ? (m100 ? CRS100_ON_CYC : CRS10_ON_CYC)
                                   : (m100 ? CRS100_OFF_CYC : CRS10_OFF_CYC);

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            CRS <= 1'b0;
            crs_cnt <= '0;
        end
        else if (ract_s == CRS)
        begin
            crs_cnt <= '0;
        end
        else if (crs_cnt >= crs_len - ONE_C)
        begin
            CRS <= ract_s;
            crs_cnt <= '0;
        end
        else
        begin
            crs_cnt <= crs_cnt + ONE_C;
        end
    end

    // Receive clock: local divider, phases held for the recovered edge when locked
    logic rx_clk;
    logic [CW-1:0] rx_cnt;
    logic rcv_seen;
    wire [CW-1:0] rx_len = rx_half(mode);
    wire rx_phase_end = (rx_cnt >= rx_len - ONE_C) && (!ract_s || rcv_seen || rcv_edge);
    wire rx_fall_ev = rx_phase_end && rx_clk;

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rx_clk <= 1'b0;
            rx_cnt <= '0;
            rcv_seen <= 1'b0;
        end
        else if (rx_phase_end)
        begin
            rx_clk <= !rx_clk;
            rx_cnt <= '0;
            rcv_seen <= 1'b0;
        end
        else
        begin
            // Saturating, so a stretched phase only ever grows
            if (rx_cnt < rx_len - ONE_C)
            begin
                rx_cnt <= rx_cnt + ONE_C;
            end
            if (rcv_edge)
            begin
                rcv_seen <= 1'b1;
            end
        end
    end
    assign RX_CLK = rx_clk;

    // Receive deserialiser and latency gate
    logic [NIB_W-1:0] rx_sreg;
    logic [2:0] rx_nb;
    logic [NIB_W-1:0] rx_hold;
    logic rx_hold_v;
    logic [CW-1:0] lat_cnt;
    wire [CW-1:0] rx_lat = m100 ? RX100_LAT_CYC : RX10_LAT_CYC;
    wire rx_open = (lat_cnt >= rx_lat);
    wire [NIB_W-1:0] rx_next = {rxd_s, rx_sreg[NIB_W-1:1]};
    wire rx_word = rcv_edge && ract_s && (rx_nb == word_bits - 3'h1);

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rx_sreg <= '0;
            rx_nb <= '0;
            lat_cnt <= '0;
        end
        else
        begin
            lat_cnt <= !ract_s ? '0 : (rx_open ? lat_cnt : lat_cnt + ONE_C);
            if (!ract_s || rx_word)
            begin
                rx_nb <= '0;
            end
            else if (rcv_edge)
            begin
                rx_nb <= rx_nb + 3'h1;
            end
            if (rcv_edge && ract_s)
            begin
                rx_sreg <= rx_next;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rx_hold <= '0;
            rx_hold_v <= 1'b0;
            RXD <= '0;
            RX_DV <= 1'b0;
        end
        else
        begin
            if (rx_fall_ev)
            begin
                // Change on the fall leaves a half period before the MAC samples
                RXD <= rx_hold;
                RX_DV <= rx_hold_v && rx_open && ract_s;
                rx_hold_v <= 1'b0;
            end
            // A new word wins over the clear
            if (rx_word)
            begin
                rx_hold <= m10ser ? {3'h0, rxd_s} : rx_next;
                rx_hold_v <= 1'b1;
            end
        end
    end

    // Checks
    localparam int A_LEAD100 = int'(TX100_LEAD_CYC) + 1;
    localparam int A_LEAD10 = int'(TX10_LEAD_CYC) + 1;
    localparam int A_T10H = int'(TX10N_HALF_CYC) - 1;
    localparam int A_CRS_ON = int'(CRS100_ON_CYC);
    localparam int A_CRS_OFF = int'(CRS100_OFF_CYC);
    localparam int A_EOP_REST = int'(EOP_CYC) - 8;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    sequence s_tx_start;
        start_ev;
    endsequence
    sequence s_tx_stop;
        stop_ev;
    endsequence

    property p_j_lead;
        s_tx_start ##0 m100 |-> ##A_LEAD100 LINE_TX_SOS;
    endproperty
    a_j_lead: assert property (p_j_lead) else $error("J start latency wrong");
    property p_t_lead;
        s_tx_stop ##0 m100 |-> ##A_LEAD100 LINE_TX_EOS;
    endproperty
    a_t_lead: assert property (p_t_lead) else $error("T start latency wrong");
    property p_crs_on;
        $rose(ract_s) && m100 |-> ##A_CRS_ON CRS;
    endproperty
    a_crs_on: assert property (p_crs_on) else $error("carrier sense on delay wrong");
    property p_crs_off;
        $fell(ract_s) && m100 && CRS |-> ##A_CRS_OFF !CRS;
    endproperty
    a_crs_off: assert property (p_crs_off) else $error("carrier sense off delay wrong");
    property p_tx100_clk;
        $rose(tx_clk) && m100 |-> tx_clk[*2] ##1 !tx_clk[*2] ##1 tx_clk;
    endproperty
    a_tx100_clk: assert property (p_tx100_clk) else $error("100M TX clock shape wrong");
    property p_samp_fall;
        push_ev && m10nib |=> $fell(tx_clk);
    endproperty
    a_samp_fall: assert property (p_samp_fall) else $error("nibble sample not at fall");
    property p_tx10_hi;
        $rose(tx_clk) && m10nib |-> ##A_T10H tx_clk ##1 !tx_clk;
    endproperty
    a_tx10_hi: assert property (p_tx10_hi) else $error("10M TX clock high time wrong");
    property p_dv_fall;
        $changed(RX_DV) |-> $fell(rx_clk);
    endproperty
    a_dv_fall: assert property (p_dv_fall) else $error("RX valid moved off the fall");
    property p_rx_min;
        $rose(rx_clk) && m100 |-> rx_clk[*2];
    endproperty
    a_rx_min: assert property (p_rx_min) else $error("RX clock phase too short");
    property p_txser_clk;
        $rose(tx_clk) && m10ser |-> tx_clk[*3] ##1 !tx_clk[*7] ##1 tx_clk;
    endproperty
    a_txser_clk: assert property (p_txser_clk) else $error("serial TX clock shape wrong");
    property p_tx10_lead;
        s_tx_start ##0 !m100 |-> ##A_LEAD10 LINE_TX_SOS;
    endproperty
    a_tx10_lead: assert property (p_tx10_lead) else $error("10M start latency wrong");
    property p_eop;
        LINE_TX_EOS && !m100 |-> LINE_TXD[*8] ##A_EOP_REST LINE_TXD ##1 !LINE_TXD;
    endproperty
    a_eop: assert property (p_eop) else $error("end of packet high time wrong");
endmodule

// ### common/phy_timing_pkg.sv
// Package: timing constants, modes and line states of the MAC-side media timing block
package phy_timing_pkg;

    localparam int CLK_NS = 10;
    localparam int CW = 8;
    localparam int SYNC_CYC = 2;
    localparam int NIB_W = 4;
    localparam int WORD_W = 5;
    localparam int MARK_BIT = 4;

    // Nearest whole cycle, never below one
    function automatic logic [CW-1:0] ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS / 2) / CLK_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return c[CW-1:0];
    endfunction

    localparam int BIT100_NS = 10;
    localparam int BIT10_NS = 100;
    localparam int TX100_HALF_NS = 20;
    localparam int TX10N_HALF_NS = 200;
    localparam int TXSER_HI_NS = 25;
    localparam int TXSER_LO_NS = 75;
    localparam int RX10N_HALF_NS = 200;
    localparam int RXSER_HALF_NS = 50;
    localparam int TX100_LAT_BITS = 5;
    localparam int TX10_LAT_TENTHS = 35;
    localparam int CRS_ON_BITS = 20;
    localparam int CRS_OFF_BITS = 24;
    localparam int RX_LAT_BITS = 24;
    localparam int EOP_HI_NS = 300;
    localparam int EOP_MIN_NS = 250;

    localparam logic [CW-1:0] ONE_C = CW'(1);
    localparam logic [CW-1:0] BIT100_CYC = ns_to_cyc(BIT100_NS);
    localparam logic [CW-1:0] BIT10_CYC = ns_to_cyc(BIT10_NS);
    localparam logic [CW-1:0] TX100_HALF_CYC = ns_to_cyc(TX100_HALF_NS);
    localparam logic [CW-1:0] TX10N_HALF_CYC = ns_to_cyc(TX10N_HALF_NS);
    localparam logic [CW-1:0] TXSER_HI_CYC = ns_to_cyc(TXSER_HI_NS);
    // Low phase takes the rest of the bit; rounding both halves up would break 10 MHz
    localparam logic [CW-1:0] TXSER_LO_CYC = ns_to_cyc(BIT10_NS) - TXSER_HI_CYC;
    localparam logic [CW-1:0] RX10N_HALF_CYC = ns_to_cyc(RX10N_HALF_NS);
    localparam logic [CW-1:0] RXSER_HALF_CYC = ns_to_cyc(RXSER_HALF_NS);
    localparam logic [CW-1:0] TX100_LEAD_CYC = ns_to_cyc(TX100_LAT_BITS * BIT100_NS);
    localparam logic [CW-1:0] TX10_LEAD_CYC = ns_to_cyc(TX10_LAT_TENTHS * BIT10_NS / 10);
    localparam logic [CW-1:0] EOP_CYC = ns_to_cyc(EOP_HI_NS);
    localparam logic [CW-1:0] EOP_MIN_CYC = CW'((EOP_MIN_NS + CLK_NS - 1) / CLK_NS);
    // Line-side figures lose the input synchroniser delay
    localparam logic [CW-1:0] CRS100_ON_CYC = ns_to_cyc(CRS_ON_BITS * BIT100_NS - SYNC_CYC * CLK_NS);
    localparam logic [CW-1:0] CRS100_OFF_CYC = ns_to_cyc(CRS_OFF_BITS * BIT100_NS - SYNC_CYC * CLK_NS);
    localparam logic [CW-1:0] CRS10_ON_CYC = ns_to_cyc(CRS_ON_BITS * BIT10_NS - SYNC_CYC * CLK_NS);
    localparam logic [CW-1:0] CRS10_OFF_CYC = ns_to_cyc(CRS_OFF_BITS * BIT10_NS - SYNC_CYC * CLK_NS);
    localparam logic [CW-1:0] RX100_LAT_CYC = ns_to_cyc(RX_LAT_BITS * BIT100_NS - SYNC_CYC * CLK_NS);
    localparam logic [CW-1:0] RX10_LAT_CYC = ns_to_cyc(RX_LAT_BITS * BIT10_NS - SYNC_CYC * CLK_NS);

    typedef enum logic [1:0] {
        MODE_100 = 2'h0,
        MODE_10NIB = 2'h1,
        MODE_10SER = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        TXS_IDLE = 2'h0,
        TXS_LEAD = 2'h1,
        TXS_DATA = 2'h3,
        TXS_TAIL = 2'h2
    } tx_state_t;

endpackage

// ### design/media_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module media_fifo
#(
    parameter int W = 5,
    parameter int DEPTH = 32
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_chk
        $error("media_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire do_wr = in_valid && !full;
    wire do_rd = out_ready && !empty;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ### dv/mac_model.sv
// MAC-side transmit model: one packet of n units per go pulse
`timescale 1ns/1ps
module mac_model
(
    input wire logic clk,
    input wire logic tx_clk,
    input wire logic go,
    input wire logic [7:0] n,
    output logic tx_en,
    output logic [3:0] txd
);
    logic prev = 1'b0;
    logic run = 1'b0;
    logic en_q = 1'b0;
    logic [3:0] d_q = 4'h0;
    logic [7:0] idx = 8'h00;
    assign tx_en = en_q;
    assign txd = d_q;
    always @(posedge clk)
    begin
        prev <= tx_clk;
        if (go)
            run <= 1'b1;
        // Launch just after a clock rise, clear of the sampling edge
        if (tx_clk && !prev && run)
        begin
            en_q <= idx != n;
            d_q <= 4'h5 + 4'h3 * idx[3:0];
            idx <= (idx == n) ? 8'h00 : idx + 8'h01;
            run <= idx != n;
        end
    end
endmodule

// ### dv/tb_top.sv
// Top testbench: transmit and receive timing in all three modes
`timescale 1ns/1ps
module tb_top;
    import phy_timing_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] mode_sel = 2'h0;
    logic go = 1'b0;
    logic line_rclk = 1'b0;
    logic line_rx_active = 1'b0;
    logic line_rxd = 1'b0;
    logic tx_en, tx_clk, rx_clk, rx_dv, crs, line_txd, sos, eos, lost, pol, ser, prx, act;
    logic cap = 1'b0;
    logic intail = 1'b0;
    logic [3:0] txd, rxd;
    logic [4:0] prev_rx;
    logic [39:0] h;
    logic q[$];
    int error_cnt = 0;
    int n_compared = 0;
    int bit_c, lead, rmin, thi, tlo, cnt, tail, ph, tph, dv_seen;
    // Last pass uses the spare code, which must behave as 100M
    logic [1:0] modes[4] = '{MODE_100, MODE_10NIB, MODE_10SER, 2'h2};
    int bits[4] = '{1, 10, 10, 1};
    // Lead in cycles: 5 bits at 10 ns, 3.5 bits at 100 ns
    int leads[4] = '{5, 35, 35, 5};
    int rmins[4] = '{2, 20, 5, 2};
    int his[4] = '{2, 20, 3, 2};
    int tlos[4] = '{2, 20, 7, 2};
    always #5 clk_sys = ~clk_sys;
    phy_media_timing i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .MODE_SEL(mode_sel), .TX_EN(tx_en), .TXD(txd),
        .TX_CLK(tx_clk), .RX_CLK(rx_clk), .RXD(rxd), .RX_DV(rx_dv), .CRS(crs), .TX_LOST(lost),
        .LINE_TXD(line_txd), .LINE_TX_ACTIVE(act), .LINE_TX_SOS(sos), .LINE_TX_EOS(eos),
        .LINE_RCLK(line_rclk), .LINE_RX_ACTIVE(line_rx_active), .LINE_RXD(line_rxd));
    mac_model i_mac (.clk(clk_sys), .tx_clk(tx_clk), .go(go), .n(8'h08), .tx_en(tx_en), .txd(txd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    always @(negedge clk_sys)
    begin
        if (sos || (eos && bit_c == 1))
            chk({h[lead-1], h[lead]}, {pol, !pol}, "launch edge");
        if (sos)
            cnt = 0;
        cap = sos || (cap && !eos);
        intail = (eos || intail) && line_txd;
        if (intail)
            tail++;
        if (cap || intail)
            chk(act, 1, "line active");
        if (cap && cnt % bit_c == 0)
            q.push_back(line_txd);
        cnt++;
        if (!rstn)
            tph = -1;
        else if (tx_clk !== h[0])
        begin
            if (tph > 0)
                chk(tph, h[0] ? thi : tlo, "tx phase");
            tph = (tph < 0) ? 0 : 1;
        end
        else if (tph > 0)
            tph++;
        if (!rstn)
            ph = -1;
        else if (rx_clk !== prx)
        begin
            if (ph > 0)
                chk(ph >= rmin, 1, "rx phase");
            ph = (ph < 0) ? 0 : 1;
        end
        else if (ph > 0)
            ph++;
        if (rstn && {rxd, rx_dv} !== prev_rx && !(prx && !rx_clk))
            chk(0, 1, "rx output moved off clock fall");
        if (rx_dv && !ser)
            chk(rxd, 4'h6, "rx nibble");
        if (rx_dv)
            dv_seen++;
        prx = rx_clk;
        prev_rx = {rxd, rx_dv};
        h = {h[38:0], tx_clk};
    end
    task automatic setup(input int i);
        @(posedge clk_sys);
        rstn <= 1'b0;
        mode_sel <= modes[i];
        bit_c = bits[i];
        lead = leads[i];
        pol = i != 1;
        ser = i == 2;
        rmin = rmins[i];
        thi = his[i];
        tlo = tlos[i];
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic txp();
        logic [3:0] v;
        q.delete();
        tail = 0;
        @(posedge clk_sys);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (int k = 0; k < 5000 && !(tail > 0 && !intail); k++)
            @(negedge clk_sys);
        chk(q.size(), ser ? 8 : 32, "unit count");
        for (int k = 0; k < q.size() && k < 32; k++)
        begin
            v = 4'h5 + 4'h3 * 4'(ser ? k : k / 4);
            chk(q[k], v[ser ? 0 : k % 4], "line bit");
        end
        chk(tail, bit_c == 1 ? 1 : 30, "end high time");
        chk(act, 0, "line active after tail");
        chk(lost, 0, "lost flag");
    endtask
    task automatic rxf();
        int k;
        dv_seen = 0;
        line_rxd = 1'b0;
        @(posedge clk_sys);
        line_rx_active <= 1'b1;
        fork
            begin
                int b = 0;
                #40;
                // Link clock only runs inside the frame
                while (line_rx_active)
                begin
                    #62.5 line_rclk = ~line_rclk;
                    b = b + (line_rclk ? 0 : 1);
                    line_rxd = b[0] ^ b[1];
                end
                line_rclk = 1'b0;
                line_rxd = ~line_rxd;
            end
        join_none
        for (k = 0; k < 1000 && !crs; k++)
            @(negedge clk_sys);
        chk(k - 1, 20 * bit_c, "carrier on");
        for (k = 0; k < 3000 && dv_seen == 0; k++)
            @(negedge clk_sys);
        chk(dv_seen > 0, 1, "rx valid seen");
        repeat (150) @(posedge clk_sys);
        line_rx_active <= 1'b0;
        for (k = 0; k < 1000 && crs; k++)
            @(negedge clk_sys);
        chk(k - 1, 24 * bit_c, "carrier off");
    endtask
    task automatic results();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #500000;
        error_cnt++;
        results();
    end
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            setup(i);
            txp();
            rxf();
        end
        results();
    end
endmodule
